// *** shared/aoc_pkg.sv ***
// constants and types for the dc offset correction control block
package aoc_pkg;
	localparam int AOC_AW = 10;
	localparam int AOC_DW = 32;
	localparam int AOC_SW = 14;
	localparam int AOC_ACC_W = 47;
	localparam int AOC_FRAC = 31;
	localparam int AOC_TAU_LOG2_BASE = 20;
	localparam logic [3:0] AOC_TAU_SHIFT_TOP = 4'(AOC_FRAC - AOC_TAU_LOG2_BASE);
	localparam logic [3:0] AOC_TAU_CODE_MAX = 4'hb;
	////////////////////////////////////////////////////////////////
	localparam logic [7:0] AOC_IDX_FMT = 8'h3d;
	localparam logic [7:0] AOC_IDX_PED = 8'hbf;
	localparam logic [7:0] AOC_IDX_TAU = 8'hcf;
	localparam logic [7:0] AOC_IDX_SPD = 8'hdf;
	localparam logic [7:0] AOC_IDX_STAT = 8'he0;
	localparam logic [7:0] AOC_REG_RST = 8'h00;
	localparam logic [7:0] AOC_MASK_FMT = 8'he0;
	localparam logic [7:0] AOC_MASK_PED = 8'hfc;
	localparam logic [7:0] AOC_MASK_TAU = 8'hbc;
	localparam logic [7:0] AOC_MASK_SPD = 8'h30;
	////////////////////////////////////////////////////////////////
	localparam int AOC_EN_BIT = 5;
	localparam int AOC_HOLD_BIT = 7;
	localparam int AOC_PED_HI = 7;
	localparam int AOC_PED_LO = 2;
	localparam int AOC_PED12_LO = 4;
	localparam int AOC_TAU_HI = 5;
	localparam int AOC_TAU_LO = 2;
	localparam int AOC_SPD_HI = 5;
	localparam int AOC_SPD_LO = 4;
	localparam logic [1:0] AOC_LOWSPD_ON = 2'b11;
	localparam int AOC_STAT_LS_BIT = 16;
	localparam int AOC_STAT_HOLD_BIT = 17;
	////////////////////////////////////////////////////////////////
	localparam logic [15:0] AOC_MID = 16'h2000;
	localparam logic [15:0] AOC_MAXC = 16'h3fff;
	typedef enum logic [1:0] {
		AOC_BUS_IDLE = 2'b01,
		AOC_BUS_DONE = 2'b10
	} aoc_bus_t;
endpackage

// *** verilog/aoc_ctrl.sv ***
// dc offset correction loop with pedestal, hold, time constant and low-speed select
`timescale 1ns/1ps

// Notes on behaviour
// RL1 - full-width variant takes the signed pedestal from bits 7 to 2
// RL2 - narrow variant takes the pedestal only from bits 7 to 4
// RL3 - pedestal field is two's complement LSBs, +31 down to -32
// RL4 - enabled loop with zero pedestal settles output at mid-code
// RL5 - settled output equals mid-code plus the programmed pedestal
// RL6 - hold clear and loop enabled: estimate keeps updating every sample
// RL7 - hold set and loop enabled: estimate frozen, last value still applied
// RL8 - time constant code in bits 5-2, 1M cycles doubling up to 2G
// RL9 - codes above 1011 are reserved; logic keeps the largest defined constant
// RL10 - low-speed mode only when speed field bits 5-4 hold 11
// RL11 - low-speed mode off for 00, 01, 10 and after reset
// RL12 - software enables low-speed mode at or below 80 MSPS only
// RL13 - software writes zero to unused bits of the three registers
// RL14 - pedestal, hold/time constant and speed registers reset to zero
// RL15 - loop runs only while enable bit 5 of format register is set
// RL16 - first-order loop accumulates output-minus-target error scaled by 1/tau
module aoc_ctrl (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic [aoc_pkg::AOC_AW-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [aoc_pkg::AOC_DW-1:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [aoc_pkg::AOC_DW-1:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic narrow_variant,
	input wire logic sample_strobe,
	input wire logic [aoc_pkg::AOC_SW-1:0] adc_sample,
	output logic [aoc_pkg::AOC_SW-1:0] corrected_sample,
	output logic corrected_valid,
	output logic low_speed_mode
);
	import aoc_pkg::*;

	function automatic logic [AOC_SW-1:0] sat_code(input logic signed [15:0] v);
		if (v[15]) begin
			return '0;
		end
		if (v > $signed(AOC_MAXC)) begin
			return AOC_MAXC[AOC_SW-1:0];
		end
		return v[AOC_SW-1:0];
	endfunction

	////////////////////////////////////////////////////////////////
	// register bus
	aoc_bus_t bus_state;
	aoc_bus_t next_bus_state;
	logic [7:0] fmt_reg;
	logic [7:0] ped_reg;
	logic [7:0] tau_reg;
	logic [7:0] spd_reg;

	wire logic [7:0] idx = avs_address[AOC_AW-1:2];
	wire logic aligned = (avs_address[1:0] == 2'b00);
	wire logic req = avs_read | avs_write;
	wire logic in_idle = (bus_state == AOC_BUS_IDLE);
	wire logic wr_en = avs_write && !in_idle && aligned && avs_byteenable[0];
	wire logic wr_fmt = wr_en && (idx == AOC_IDX_FMT);
	wire logic wr_ped = wr_en && (idx == AOC_IDX_PED);
	wire logic wr_tau = wr_en && (idx == AOC_IDX_TAU);
	wire logic wr_spd = wr_en && (idx == AOC_IDX_SPD);
	wire logic [7:0] wbyte = avs_writedata[7:0];

	assign avs_waitrequest = req && in_idle;

	always_comb begin
		unique case (bus_state)
			AOC_BUS_IDLE: next_bus_state = req ? AOC_BUS_DONE : AOC_BUS_IDLE;
			AOC_BUS_DONE: next_bus_state = AOC_BUS_IDLE;
			default: next_bus_state = AOC_BUS_IDLE;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			bus_state <= AOC_BUS_IDLE;
		end else begin
			bus_state <= next_bus_state;
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			fmt_reg <= AOC_REG_RST;
			ped_reg <= AOC_REG_RST; // RL14
			tau_reg <= AOC_REG_RST; // RL14
			spd_reg <= AOC_REG_RST; // RL14 RL11
		end else begin
			if (wr_fmt) begin
				fmt_reg <= wbyte & AOC_MASK_FMT;
			end
			if (wr_ped) begin
				ped_reg <= wbyte & AOC_MASK_PED;
			end
			if (wr_tau) begin
				tau_reg <= wbyte & AOC_MASK_TAU;
			end
			if (wr_spd) begin
				spd_reg <= wbyte & AOC_MASK_SPD;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// correction loop
	logic signed [AOC_ACC_W-1:0] acc;
	logic signed [AOC_ACC_W-1:0] next_acc;

	wire logic loop_en = fmt_reg[AOC_EN_BIT]; // RL15
	wire logic hold = tau_reg[AOC_HOLD_BIT];
	wire logic [3:0] tau_code = tau_reg[AOC_TAU_HI:AOC_TAU_LO]; // RL8
	wire logic [3:0] tau_eff = (tau_code > AOC_TAU_CODE_MAX) ? AOC_TAU_CODE_MAX : tau_code; // RL9
	wire logic [3:0] shift = AOC_TAU_SHIFT_TOP - tau_eff; // RL8
	wire logic [5:0] ped_wide = ped_reg[AOC_PED_HI:AOC_PED_LO]; // RL1
	wire logic [5:0] ped_narrow = {ped_reg[AOC_PED_HI:AOC_PED12_LO], 2'b00}; // RL2
	wire logic [5:0] ped6 = narrow_variant ? ped_narrow : ped_wide;
	wire logic [15:0] ped_ext = {{10{ped6[5]}}, ped6}; // RL3
	wire logic signed [15:0] target = $signed(AOC_MID + ped_ext); // RL4 RL5
	wire logic signed [15:0] est = acc[AOC_ACC_W-1:AOC_FRAC];
	wire logic signed [15:0] est_used = loop_en ? est : 16'sh0000; // RL15
	wire logic signed [15:0] diff = $signed({2'b00, adc_sample}) - est_used;
	wire logic signed [15:0] err = diff - target; // RL16
	wire logic signed [AOC_ACC_W-1:0] err_ext = {{(AOC_ACC_W-16){err[15]}}, err};
	wire logic signed [AOC_ACC_W-1:0] step = err_ext <<< shift; // RL16
	wire logic [AOC_SW-1:0] corr = sat_code(diff);
	wire logic track = loop_en && !hold && sample_strobe; // RL6

	always_comb begin
		if (!loop_en) begin
			next_acc = '0; // RL15
		end else if (track) begin
			next_acc = acc + step; // RL6 RL16
		end else begin
			next_acc = acc; // RL7
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			acc <= '0;
		end else begin
			acc <= next_acc;
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			corrected_sample <= '0;
			corrected_valid <= 1'b0;
		end else begin
			corrected_valid <= sample_strobe;
			if (sample_strobe) begin
				corrected_sample <= corr; // RL7
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			low_speed_mode <= 1'b0; // RL11
		end else begin
			low_speed_mode <= (spd_reg[AOC_SPD_HI:AOC_SPD_LO] == AOC_LOWSPD_ON); // RL10
		end
	end

	////////////////////////////////////////////////////////////////
	// read data
	logic [AOC_DW-1:0] stat_word;
	logic [AOC_DW-1:0] rd_word;

	always_comb begin
		stat_word = '0;
		stat_word[15:0] = est;
		stat_word[AOC_STAT_LS_BIT] = low_speed_mode;
		stat_word[AOC_STAT_HOLD_BIT] = loop_en && hold;
	end

	wire logic [AOC_DW-1:0] rd_fmt = {24'h000000, fmt_reg};
	wire logic [AOC_DW-1:0] rd_ped = {24'h000000, ped_reg};
	wire logic [AOC_DW-1:0] rd_tau = {24'h000000, tau_reg};
	wire logic [AOC_DW-1:0] rd_spd = {24'h000000, spd_reg};

	assign rd_word = !aligned ? '0 :
		(idx == AOC_IDX_FMT) ? rd_fmt :
		(idx == AOC_IDX_PED) ? rd_ped :
		(idx == AOC_IDX_TAU) ? rd_tau :
		(idx == AOC_IDX_SPD) ? rd_spd :
		(idx == AOC_IDX_STAT) ? stat_word : '0;

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			avs_readdata <= '0;
		end else if (avs_read && in_idle) begin
			avs_readdata <= rd_word;
		end
	end

	////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (sys_rst);

	a_reset_clear: assert property ( // RL14
		$fell(sys_rst) |-> (ped_reg == 8'h00 && tau_reg == 8'h00 && spd_reg == 8'h00
			&& !low_speed_mode))
		else $error("control registers not zero after reset");

	a_ped_wide: assert property ( // RL1
		!narrow_variant |-> target == $signed(AOC_MID + {{10{ped_reg[7]}}, ped_reg[7:2]}))
		else $error("full-width pedestal wrong");

	a_ped_narrow: assert property ( // RL2
		narrow_variant |-> target == $signed(AOC_MID + {{10{ped_reg[7]}}, ped_reg[7:4], 2'b00}))
		else $error("narrow pedestal wrong");

	a_ped_range: assert property ( // RL3
		!narrow_variant |-> (target >= 16'sh1fe0 && target <= 16'sh201f))
		else $error("pedestal outside -32..+31");

	a_settle_target: assert property ( // RL4 RL5
		loop_en && sample_strobe && err == 16'sh0000 && diff >= 0
			|=> corrected_sample == $past(target[AOC_SW-1:0]) && corrected_valid)
		else $error("settled output not at target");

	a_track_update: assert property ( // RL6
		track && err != 16'sh0000 |=> acc != $past(acc))
		else $error("estimate not updated while tracking");

	a_hold_freeze: assert property ( // RL7
		loop_en && hold ##1 loop_en && hold |-> $stable(acc))
		else $error("estimate moved while held");

	a_tau_step: assert property ( // RL8 RL16
		track && tau_code == 4'h0 |=> acc == $past(acc) + ($past(err_ext) <<< 11))
		else $error("step not scaled for shortest time constant");

	a_tau_reserved: assert property ( // RL9
		tau_code > AOC_TAU_CODE_MAX |-> shift == 4'h0)
		else $error("reserved time constant not clamped");

	a_low_speed_on: assert property ( // RL10 RL11
		wr_spd |=> ##1 low_speed_mode == ($past(wbyte[5:4], 2) == 2'b11))
		else $error("low-speed mode does not follow write");

	a_loop_off: assert property ( // RL15
		!loop_en && sample_strobe |=> acc == '0 && corrected_sample == sat_code(
			$signed({2'b00, $past(adc_sample)})))
		else $error("disabled loop altered samples");

	a_bus_answer: assert property (
		req && in_idle |=> !avs_waitrequest && bus_state == AOC_BUS_DONE)
		else $error("bus answer late");

	c_hold: cover property (loop_en && hold && sample_strobe);
	c_low_speed: cover property ($rose(low_speed_mode));
	c_reserved_tau: cover property (track && tau_code > AOC_TAU_CODE_MAX);
	c_neg_ped: cover property (loop_en && ped6[5] && sample_strobe);
endmodule

// *** sim/aoc_ctrl_test.sv ***
// self-checking bench for the dc offset correction control block
`timescale 1ns/1ps
module aoc_ctrl_test;
	import aoc_pkg::*;
	logic mclk, sys_rst, avs_read, avs_write, narrow_variant, sample_strobe;
	logic [AOC_AW-1:0] avs_address;
	logic [AOC_DW-1:0] avs_writedata, avs_readdata;
	logic [3:0] avs_byteenable;
	logic avs_waitrequest, corrected_valid, low_speed_mode, en, hold;
	logic [AOC_SW-1:0] adc_sample, corrected_sample;
	int fail_count, comparisons, ped, shift;
	logic signed [46:0] acc;
	logic [31:0] rd;
	aoc_ctrl aoc_ctrl_i (.mclk(mclk), .sys_rst(sys_rst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .narrow_variant(narrow_variant),
		.sample_strobe(sample_strobe), .adc_sample(adc_sample),
		.corrected_sample(corrected_sample), .corrected_valid(corrected_valid),
		.low_speed_mode(low_speed_mode));
	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end
	////////////////////////////////////////////////////////////////
	task give_verdict;
		$display("comparisons %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// one avalon transfer, held until waitrequest is sampled low at a falling edge
	task bus(input logic rw, input logic [7:0] idx, input logic [7:0] wd);
		int k;
		logic w;
		@(posedge mclk);
		avs_read <= rw;
		avs_write <= !rw;
		avs_address <= {idx, 2'b00};
		avs_writedata <= {24'h0, wd};
		for (k = 0; k < 20; k++) begin
			@(negedge mclk);
			w = avs_waitrequest;
			@(posedge mclk);
			if (!w) break;
		end
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (k == 20) begin
			fail_count++;
			give_verdict();
		end
	endtask
	// program the loop and mirror the settings in the reference model
	task cfg(input logic [7:0] fmt, input logic [7:0] pr, input logic [7:0] tr, input logic nv);
		bus(0, AOC_IDX_PED, pr);
		narrow_variant <= nv;
		bus(0, AOC_IDX_TAU, tr);
		bus(0, AOC_IDX_FMT, fmt);
		en = fmt[5];
		hold = tr[7];
		shift = 11 - ((tr[5:2] > 11) ? 11 : tr[5:2]);
		ped = nv ? 4 * int'($signed(pr[7:4])) : int'($signed(pr[7:2]));
		if (!en) acc = '0;
	endtask
	// strobe n equal samples and compare each against the first-order model
	task run(input logic [13:0] x, input int n);
		int d, e;
		logic signed [15:0] est;
		repeat (n) begin
			est = acc[46:31];
			d = en ? int'(x) - int'(est) : int'(x);
			e = d - 'h2000 - ped;
			@(posedge mclk);
			sample_strobe <= 1'b1;
			adc_sample <= x;
			@(posedge mclk);
			sample_strobe <= 1'b0;
			#1;
			chk(32'(corrected_valid), 1);
			chk(32'(corrected_sample), (d < 0) ? 0 : (d > 16383) ? 16383 : d);
			if (en && !hold) acc = acc + 47'(longint'(e) <<< shift);
		end
	endtask
	////////////////////////////////////////////////////////////////
	task t_reset;
		bus(1, AOC_IDX_PED, 0);
		chk(rd, 0);
		bus(1, AOC_IDX_TAU, 0);
		chk(rd, 0);
		bus(1, AOC_IDX_SPD, 0);
		chk(rd, 0);
		chk(32'(low_speed_mode), 0);
		bus(1, 8'h01, 0);
		chk(rd, 0);
		$display("test reset done");
	endtask
	task t_speed;
		for (int f = 0; f < 4; f++) begin
			bus(0, AOC_IDX_SPD, 8'(f << 4));
			repeat (2) @(posedge mclk);
			#1;
			chk(32'(low_speed_mode), 32'(f == 3));
		end
		bus(1, AOC_IDX_SPD, 0);
		chk(rd, 32'h30);
		bus(0, AOC_IDX_SPD, 0);
		$display("test speed done");
	endtask
	task t_ped;
		logic [7:0] pr [6] = '{8'h00, 8'h7c, 8'hfc, 8'h80, 8'h7c, 8'hf0};
		for (int i = 0; i < 6; i++) begin
			cfg(8'h00, pr[i], 0, i > 3);
			run(14'h1234, 2);
			cfg(8'h20, pr[i], 0, i > 3);
			run(14'(32'h2000 + ped), 3);
			run(14'(32'h1fff + ped), 3);
		end
		$display("test pedestal done");
	endtask
	task t_tau;
		for (int c = 0; c < 16; c++) begin
			cfg(8'h00, 0, 0, 0);
			cfg(8'h20, 0, 8'(c << 2), 0);
			run(14'h3fff, 600);
		end
		$display("test time constant done");
	endtask
	task t_hold;
		cfg(8'h00, 0, 0, 0);
		cfg(8'h20, 0, 0, 0);
		run(14'h3fff, 600);
		cfg(8'h20, 0, 8'h80, 0);
		run(14'h0100, 300);
		bus(1, AOC_IDX_STAT, 0);
		chk(rd, {14'h0000, 2'b10, 16'(acc[46:31])});
		cfg(8'h20, 0, 8'h00, 0);
		run(14'h0100, 300);
		cfg(8'h00, 0, 0, 0);
		run(14'h0100, 2);
		$display("test hold done");
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		sys_rst = 1'b1;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_address = '0;
		avs_writedata = '0;
		avs_byteenable = 4'h1;
		narrow_variant = 1'b0;
		sample_strobe = 1'b0;
		adc_sample = '0;
		en = 1'b0;
		hold = 1'b0;
		acc = '0;
		fail_count = 0;
		comparisons = 0;
		repeat (2) @(posedge mclk);
		sys_rst <= 1'b0;
		t_reset();
		t_speed();
		t_ped();
		t_tau();
		t_hold();
		give_verdict();
	end
endmodule
